// ==== nsx_alu.sv ====
// Nibble swap and xor file-register operations on a four-phase cycle
`timescale 1ns/1ps
module nsx_alu
  import nsx_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Instruction word, valid while phase one is active
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  // Bank select and data memory read data
  input wire logic [3:0] bank_select_register,
  input wire logic [7:0] mem_rdata,
  // Status flags in
  input wire logic flag_n_in,
  input wire logic flag_z_in,
  // Data memory access
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  // Working register and flags
  output logic [7:0] wreg,
  output logic flag_n,
  output logic flag_z,
  output logic flag_we,
  output logic busy,
  output logic done
);
  nsx_phase_t phase_q, phase_d;
  logic [15:0] ir_q;
  logic is_swap_q, is_xor_q;
  logic [7:0] data_q;
  logic [7:0] res_q;
  logic [11:0] addr_q;
  logic [7:0] wreg_q;
  logic n_q, z_q, fwe_q;
  logic rd_q, wr_q, done_q;
  logic busy_q;

  // Field decode of the incoming word
  wire [5:0] opc = instr_word[NSX_OPC_HI:NSX_OPC_LO];
  wire dec_swap = (opc == NSX_SWAP_OPC);
  wire dec_xor = (opc == NSX_XOR_OPC);
  wire dec_any = instr_valid && (dec_swap || dec_xor);
  wire [7:0] file_adr = instr_word[NSX_FILE_HI:NSX_FILE_LO];
  wire [3:0] bank = instr_word[NSX_ACC_BIT] ? bank_select_register : NSX_ACCESS_BANK;
  wire [11:0] full_adr = {bank, file_adr};
  wire dest_w = (ir_q[NSX_DEST_BIT] == NSX_DEST_W);

  // Result forming
  wire [7:0] swap_res = {data_q[NSX_LO_NIB_HI:NSX_LSB], data_q[NSX_MSB:NSX_HI_NIB_LO]};
  wire [7:0] xor_res = wreg_q ^ data_q;
  wire [7:0] alu_res = is_swap_q ? swap_res : xor_res;
  wire xor_z = (xor_res == NSX_ZERO_BYTE);
  wire xor_n = xor_res[NSX_MSB];

  // Phase sequencer: one instruction cycle of four phases
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      NSX_Q1: if (dec_any) phase_d = NSX_Q2;
      NSX_Q2: phase_d = NSX_Q3;
      NSX_Q3: phase_d = NSX_Q4;
      NSX_Q4: phase_d = NSX_Q1;
      default: phase_d = NSX_Q1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= NSX_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Decode latch in phase one
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ir_q <= 16'h0000;
      is_swap_q <= 1'b0;
      is_xor_q <= 1'b0;
      addr_q <= 12'h000;
    end else if (phase_q == NSX_Q1 && dec_any) begin
      ir_q <= instr_word;
      is_swap_q <= dec_swap;
      is_xor_q <= dec_xor;
      addr_q <= full_adr;
    end
  end

  // Read strobe in phase two, capture data at its end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= 1'b0;
      data_q <= 8'h00;
    end else begin
      rd_q <= (phase_q == NSX_Q1) && dec_any;
      if (phase_q == NSX_Q2) data_q <= mem_rdata;
    end
  end

  // Process in phase three
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      res_q <= 8'h00;
      n_q <= 1'b0;
      z_q <= 1'b0;
    end else if (phase_q == NSX_Q3) begin
      res_q <= alu_res;
      n_q <= is_xor_q ? xor_n : flag_n_in;
      z_q <= is_xor_q ? xor_z : flag_z_in;
    end
  end

  // Write destination in phase four
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wreg_q <= NSX_W_RESET;
      wr_q <= 1'b0;
      fwe_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      wr_q <= (phase_q == NSX_Q3) && !dest_w;
      fwe_q <= (phase_q == NSX_Q3) && is_xor_q;
      done_q <= (phase_q == NSX_Q3);
      if (phase_q == NSX_Q4 && dest_w) wreg_q <= res_q;
    end
  end

  // Busy flag taken from the next phase so it lines up with the phase register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (phase_d != NSX_Q1);
    end
  end

  // Output drive
  assign mem_addr = addr_q;
  assign mem_rd = rd_q;
  assign mem_wr = wr_q;
  assign mem_wdata = res_q;
  assign wreg = wreg_q;
  assign flag_n = n_q;
  assign flag_z = z_q;
  assign flag_we = fwe_q;
  assign busy = busy_q;
  assign done = done_q;

  // Checks
  sequence accept_s;
    phase_q == NSX_Q1 && dec_any;
  endsequence
  sequence write_s;
    phase_q == NSX_Q4 && done_q;
  endsequence
  sequence busy_run_s;
    busy [*3] ##1 !busy;
  endsequence

  phase_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept_s |-> ##3 write_s ##1 phase_q == NSX_Q1)
    else $error("operation not four phases");
  read_phase_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept_s |=> mem_rd && phase_q == NSX_Q2)
    else $error("read not in phase two");
  busy_span_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept_s |=> busy_run_s)
    else $error("busy not three cycles");
  rd_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    mem_rd |=> !mem_rd)
    else $error("read strobe longer than one cycle");
  done_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    done |=> !done)
    else $error("done longer than one cycle");
  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (phase_q == NSX_Q1) |-> !mem_rd && !mem_wr && !done)
    else $error("strobe outside its phase");
  bank_sel_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept_s |=> mem_addr[NSX_BANK_HI:NSX_BANK_LO] ==
      (ir_q[NSX_ACC_BIT] ? $past(bank_select_register) : NSX_ACCESS_BANK))
    else $error("wrong bank");
  addr_fld_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept_s |=> mem_addr[NSX_FILE_HI:NSX_FILE_LO] ==
      $past(instr_word[NSX_FILE_HI:NSX_FILE_LO]))
    else $error("wrong file address");
  swap_val_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (phase_q == NSX_Q3 && is_swap_q) |=>
      res_q == {$past(data_q[NSX_LO_NIB_HI:NSX_LSB]), $past(data_q[NSX_MSB:NSX_HI_NIB_LO])}
      && !flag_we)
    else $error("swap result wrong");
  swap_flags_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (phase_q == NSX_Q3 && is_swap_q) |=> flag_n == $past(flag_n_in)
      && flag_z == $past(flag_z_in))
    else $error("swap changed flags");
  xor_val_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (phase_q == NSX_Q3 && is_xor_q) |=> res_q == ($past(wreg_q) ^ $past(data_q))
      && flag_we)
    else $error("xor result wrong");
  xor_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (phase_q == NSX_Q4 && is_xor_q) |-> flag_z == (res_q == NSX_ZERO_BYTE)
      && flag_n == res_q[NSX_MSB])
    else $error("xor flags wrong");
  file_dest_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (phase_q == NSX_Q4) |-> mem_wr == ir_q[NSX_DEST_BIT])
    else $error("destination write wrong");
  w_dest_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (phase_q == NSX_Q4 && dest_w) |=> wreg == $past(res_q))
    else $error("working register not written");
  w_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(phase_q == NSX_Q4 && dest_w) |=> $stable(wreg))
    else $error("working register changed without a write");
  swap_dec_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (phase_q == NSX_Q1 && instr_valid && instr_word[NSX_OPC_HI:NSX_OPC_LO] == NSX_SWAP_OPC)
      |=> is_swap_q)
    else $error("swap not decoded");
  xor_dec_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (phase_q == NSX_Q1 && instr_valid && instr_word[NSX_OPC_HI:NSX_OPC_LO] == NSX_XOR_OPC)
      |=> is_xor_q)
    else $error("xor not decoded");
endmodule : nsx_alu

// ==== nsx_alu_tb.sv ====
// Self-checking testbench for the nibble swap and xor unit
`timescale 1ns/1ps
module nsx_alu_tb;
  import nsx_pkg::*;
  // Stimulus and observed signals
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic [15:0] instr_word = 16'h0000;
  logic instr_valid = 1'h0;
  logic [3:0] bank_reg = 4'h0;
  logic [7:0] mem_rdata = 8'h00;
  logic n_in = 1'h0;
  logic z_in = 1'h0;
  logic [11:0] mem_addr;
  logic mem_rd, mem_wr, flag_n, flag_z, flag_we, busy, done;
  logic [7:0] mem_wdata, wreg;
  logic [7:0] w_exp = 8'h00;
  int fails = 0;
  int samples_checked = 0;
  nsx_alu i_dut (.sys_clk(sys_clk), .resetn(resetn), .instr_word(instr_word),
    .instr_valid(instr_valid), .bank_select_register(bank_reg), .mem_rdata(mem_rdata),
    .flag_n_in(n_in), .flag_z_in(z_in), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .wreg(wreg), .flag_n(flag_n),
    .flag_z(flag_z), .flag_we(flag_we), .busy(busy), .done(done));
  // Clock generator
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Next edge plus drive delay
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick
  // One operation; valid stays high while busy so a second accept would show
  task automatic op(input logic [5:0] opc, input logic d, input logic a, input logic [3:0] b,
    input logic [7:0] f, input logic [7:0] rd, input logic ni, input logic zi);
    logic [7:0] res;
    logic [1:0] flg;
    res = (opc == NSX_SWAP_OPC) ? {rd[3:0], rd[7:4]} : (w_exp ^ rd);
    flg = (opc == NSX_XOR_OPC) ? {res[7], res == NSX_ZERO_BYTE} : {ni, zi};
    instr_word = {opc, d, a, f};
    instr_valid = 1'h1;
    bank_reg = b;
    n_in = ni;
    z_in = zi;
    tick();
    mem_rdata = rd;
    chk(12'({busy, mem_rd}), 12'h003);
    chk(mem_addr, {a ? b : NSX_ACCESS_BANK, f});
    tick();
    mem_rdata = ~rd;
    chk(12'({busy, mem_rd}), 12'h002);
    tick();
    chk(12'({busy, done, mem_wr, flag_we}), 12'({2'h3, d, opc == NSX_XOR_OPC}));
    chk(12'(mem_wdata), 12'(res));
    chk(12'({flag_n, flag_z}), 12'(flg));
    if (d == NSX_DEST_W) begin
      w_exp = res;
    end
    tick();
    chk(12'({busy, done, wreg}), 12'(w_exp));
  endtask : op
  // Verdict and end of run
  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    resetn = 1'h1;
    chk({busy, done, mem_rd, mem_wr, wreg}, 12'h000);
    op(NSX_XOR_OPC, 1'h0, 1'h0, 4'h7, 8'hFF, 8'hB5, 1'h0, 1'h0);
    op(NSX_XOR_OPC, 1'h1, 1'h1, 4'h5, 8'h00, 8'hAF, 1'h1, 1'h1);
    op(NSX_SWAP_OPC, 1'h1, 1'h0, 4'h9, 8'h3C, 8'h53, 1'h1, 1'h0);
    op(NSX_SWAP_OPC, 1'h0, 1'h1, 4'hF, 8'h80, 8'hA6, 1'h0, 1'h1);
    // Unknown opcode must start nothing
    instr_word = 16'hFC12;
    repeat (4) begin
      tick();
      chk(12'({busy, mem_rd}), 12'h000);
    end
    op(NSX_XOR_OPC, 1'h0, 1'h1, 4'h2, 8'h10, 8'h6A, 1'h0, 1'h0);
    op(NSX_XOR_OPC, 1'h1, 1'h0, 4'h3, 8'h01, 8'h80, 1'h0, 1'h1);
    instr_valid = 1'h0;
    wrap_up();
  end
  // Watchdog well beyond the expected run
  initial begin
    #5000;
    fails++;
    wrap_up();
  end
endmodule : nsx_alu_tb

// ==== nsx_pkg.sv ====
// Package with opcodes, field positions and phase encodings for the nibble swap / xor unit
package nsx_pkg;
  localparam logic [5:0] NSX_SWAP_OPC = 6'h0E; // Upper six bits 001110
  localparam logic [5:0] NSX_XOR_OPC = 6'h06; // Upper six bits 000110
  localparam int NSX_OPC_HI = 15;
  localparam int NSX_OPC_LO = 10;
  localparam int NSX_DEST_BIT = 9;
  localparam int NSX_ACC_BIT = 8;
  localparam int NSX_FILE_HI = 7;
  localparam int NSX_FILE_LO = 0;
  localparam int NSX_MSB = 7;
  localparam int NSX_LSB = 0;
  localparam int NSX_LO_NIB_HI = 3; // Top bit of the lower nibble
  localparam int NSX_HI_NIB_LO = 4; // Bottom bit of the upper nibble
  localparam int NSX_BANK_HI = 11;
  localparam int NSX_BANK_LO = 8;
  localparam logic [3:0] NSX_ACCESS_BANK = 4'h0; // Bank used when access bit is 0
  localparam logic [7:0] NSX_ZERO_BYTE = 8'h00;
  localparam logic [7:0] NSX_W_RESET = 8'h00;
  localparam logic NSX_DEST_W = 1'b0;
  typedef enum logic [3:0] {
    NSX_Q1 = 4'h1,
    NSX_Q2 = 4'h2,
    NSX_Q3 = 4'h4,
    NSX_Q4 = 4'h8
  } nsx_phase_t;
endpackage : nsx_pkg
